// *** rtl/irf_flag_reg.sv ***
// One 16-bit request flag register with byte-lane writes.
// Assumes set and clear vectors are on the same clock as the bus.
`timescale 1ns/100ps
module irf_flag_reg
	import irf_pkg::*;
#(
	parameter logic [15:0] RST_VAL = 16'h0000
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// Software write
	input  wire logic              wrEn,
	input  wire logic [1:0]        byteEn,
	input  wire logic [REG_W-1:0]  wrData,
	// Hardware set and acceptance clear
	input  wire logic [REG_W-1:0]  hwSet,
	input  wire logic [REG_W-1:0]  ackClr,
	// Stored flags
	output logic      [REG_W-1:0]  flags_q
);

	logic [REG_W-1:0] laneMask;
	logic [REG_W-1:0] written;
	logic [REG_W-1:0] flags_d;

	assign laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}};
	assign written  = wrEn ? ((flags_q & ~laneMask) | (wrData & laneMask)) : flags_q;
	// Source events beat both the acceptance clear and a software zero
	assign flags_d  = (written & ~ackClr) | hwSet;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= RST_VAL;
		end else if (clkEn) begin
			flags_q <= flags_d;
		end
	end

endmodule : irf_flag_reg

// *** rtl/irf_pkg.sv ***
// Constants for the two interrupt request flag registers.
// Assumes a 16-bit special function register bus on the system clock.
package irf_pkg;

	localparam int          REG_W           = 16;
	localparam int          IDX_W           = 5;

	// Register addresses
	localparam logic [15:0] ADDR_REQ_COMM   = 16'hF01A;
	localparam logic [15:0] ADDR_REQ_ANALOG = 16'hF01C;

	// Reset values
	localparam logic [15:0] RST_REQ_COMM    = 16'h0000;
	localparam logic [15:0] RST_REQ_ANALOG  = 16'h0000;

	// Bit positions, first group
	localparam int          BIT_SIO0        = 0;
	localparam int          BIT_SIO0_FIFO   = 1;
	localparam int          BIT_TWOWIRE0    = 2;
	localparam int          BIT_TWOWIRE1    = 3;
	localparam int          BIT_UART_RX     = 4;
	localparam int          BIT_UART_TX     = 5;
	localparam int          BIT_UART_FIFO   = 6;
	localparam int          BIT_LOWOSC      = 13;
	localparam int          BIT_VLSENSE     = 14;
	localparam int          BIT_MELODY0     = 15;

	// Bit positions, second group
	localparam int          BIT_SAR_ADC     = 0;
	localparam int          BIT_RC_ADC      = 1;
	localparam int          BIT_CMP0        = 4;
	localparam int          BIT_CMP1        = 5;
	localparam int          BIT_TIMER8_BASE = 8;

	// Bits that carry a source; the rest are plain storage
	localparam logic [15:0] SRC_MASK_COMM   = 16'hE07F;
	localparam logic [15:0] SRC_MASK_ANALOG = 16'hFF33;

	// Acceptance index: bit 4 picks the group, bits 3:0 the flag
	localparam logic [4:0]  IDX_NONE        = 5'h00;

	// Instruction hold after a flag or enable write
	localparam logic [1:0]  HOLD_INSTR      = 2'h1;

	typedef enum logic {
		GRP_COMM,
		GRP_ANALOG
	} irf_grp_t;

endpackage : irf_pkg

// *** rtl/irf_request_flags.sv ***
// Interrupt request flags for the communication/misc and analog/timer groups.
// Assumes peripherals, bus and CPU acceptance logic all run on mclk.
`timescale 1ns/100ps
module irf_request_flags
	import irf_pkg::*;
(
	// Clock, reset and freeze
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// Special function register bus
	input  wire logic [15:0]       sfrAddr,
	input  wire logic [1:0]        sfrByteEn,
	input  wire logic              sfrWr,
	input  wire logic              sfrRd,
	input  wire logic [15:0]       sfrWdata,
	output logic      [15:0]       sfrRdata_q,
	// Communication and misc sources
	input  wire logic              syncSerial0Req,
	input  wire logic              syncSerial0FifoReq,
	input  wire logic              twowire0Req,
	input  wire logic              twowire1Req,
	input  wire logic              uartRxReq,
	input  wire logic              uartTxReq,
	input  wire logic              uartFifoReq,
	input  wire logic              lowspeedOscSwitchReq,
	input  wire logic              voltageLevelSenseReq,
	input  wire logic              melody0Req,
	// Analog and timer sources
	input  wire logic              sarAdcReq,
	input  wire logic              rcAdcReq,
	input  wire logic              comparator0Req,
	input  wire logic              comparator1Req,
	input  wire logic [7:0]        timer8Req,
	// Enables held elsewhere
	input  wire logic [15:0]       enableFlagsCommMisc,
	input  wire logic [15:0]       enableFlagsAnalogTimers,
	input  wire logic              masterIntEnable,
	input  wire logic              enableWrCommMisc,
	input  wire logic              enableWrAnalogTimers,
	// CPU core
	input  wire logic              instrDone,
	input  wire logic              cpuAck,
	input  wire logic [IDX_W-1:0]  cpuAckIdx,
	output logic                   intReq_q,
	output logic      [IDX_W-1:0]  intIdx_q,
	// Flag state
	output logic      [REG_W-1:0]  reqFlagsCommMisc,
	output logic      [REG_W-1:0]  reqFlagsAnalogTimers
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic              hitComm;
	wire logic              hitAnalog;
	wire logic              wrComm;
	wire logic              wrAnalog;
	wire logic              anyAccessLane;

	assign anyAccessLane = |sfrByteEn;
	assign hitComm       = (sfrAddr[15:1] == ADDR_REQ_COMM[15:1]);
	assign hitAnalog     = (sfrAddr[15:1] == ADDR_REQ_ANALOG[15:1]);
	assign wrComm        = sfrWr && hitComm && anyAccessLane;
	assign wrAnalog      = sfrWr && hitAnalog && anyAccessLane;

	////////////////////////////////////////////////////////////////////////
	// Source event vectors

	wire logic [REG_W-1:0]  srcComm;
	wire logic [REG_W-1:0]  srcAnalog;

	assign srcComm = {
		melody0Req,
		voltageLevelSenseReq,
		lowspeedOscSwitchReq,
		5'h00,
		1'b0,
		uartFifoReq,
		uartTxReq,
		uartRxReq,
		twowire1Req,
		twowire0Req,
		syncSerial0FifoReq,
		syncSerial0Req
	};

	assign srcAnalog = {
		timer8Req,
		2'h0,
		comparator1Req,
		comparator0Req,
		2'h0,
		rcAdcReq,
		sarAdcReq
	};

	////////////////////////////////////////////////////////////////////////
	// Acceptance decode

	wire logic [REG_W-1:0]  ackOneHot;
	wire logic [REG_W-1:0]  ackClrComm;
	wire logic [REG_W-1:0]  ackClrAnalog;
	wire logic              ackGrpAnalog;

	assign ackGrpAnalog = cpuAckIdx[4];
	assign ackOneHot    = REG_W'(16'h0001 << cpuAckIdx[3:0]);
	assign ackClrComm   = (cpuAck && !ackGrpAnalog) ? ackOneHot : 16'h0000;
	assign ackClrAnalog = (cpuAck && ackGrpAnalog) ? ackOneHot : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Flag storage

	irf_flag_reg #(
		.RST_VAL (RST_REQ_COMM)
	) u_commFlags (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.wrEn    (wrComm),
		.byteEn  (sfrByteEn),
		.wrData  (sfrWdata),
		.hwSet   (srcComm & SRC_MASK_COMM),
		.ackClr  (ackClrComm),
		.flags_q (reqFlagsCommMisc)
	);

	irf_flag_reg #(
		.RST_VAL (RST_REQ_ANALOG)
	) u_analogFlags (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.wrEn    (wrAnalog),
		.byteEn  (sfrByteEn),
		.wrData  (sfrWdata),
		.hwSet   (srcAnalog & SRC_MASK_ANALOG),
		.ackClr  (ackClrAnalog),
		.flags_q (reqFlagsAnalogTimers)
	);

	////////////////////////////////////////////////////////////////////////
	// Qualification per flag

	wire logic [2*REG_W-1:0] flatFlags;
	wire logic [2*REG_W-1:0] flatEnable;
	wire logic [2*REG_W-1:0] flatSrcMask;
	wire logic [2*REG_W-1:0] qualified;

	assign flatFlags   = {reqFlagsAnalogTimers, reqFlagsCommMisc};
	assign flatEnable  = {enableFlagsAnalogTimers, enableFlagsCommMisc};
	assign flatSrcMask = {SRC_MASK_ANALOG, SRC_MASK_COMM};

	genvar gi;
	generate
		for (gi = 0; gi < 2*REG_W; gi++) begin : g_qual
			// Storage-only bits never reach the CPU
			assign qualified[gi] = flatFlags[gi] && flatEnable[gi] && flatSrcMask[gi]
				&& masterIntEnable;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Lowest index wins

	function automatic logic [IDX_W-1:0] firstSet(input logic [2*REG_W-1:0] vec);
		logic [IDX_W-1:0] idx;
		idx = IDX_NONE;
		for (int i = 2*REG_W-1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction : firstSet

	wire logic              anyQualified;
	wire logic [IDX_W-1:0]  pickIdx;

	assign anyQualified = |qualified;
	assign pickIdx      = firstSet(qualified);

	////////////////////////////////////////////////////////////////////////
	// Hold after a flag or enable write

	typedef enum logic [1:0] {
		HOLD_IDLE,
		HOLD_ARMED,
		HOLD_WAIT
	} irf_hold_t;

	irf_hold_t   holdState_q;
	irf_hold_t   holdState_d;
	logic [1:0]  holdCnt_q;
	logic [1:0]  holdCnt_d;
	wire logic   anyCfgWrite;
	wire logic   holdActive;

	assign anyCfgWrite = wrComm || wrAnalog || enableWrCommMisc || enableWrAnalogTimers;

	always_comb begin
		holdState_d = holdState_q;
		holdCnt_d   = holdCnt_q;
		unique case (holdState_q)
			HOLD_IDLE: begin
				if (anyCfgWrite) begin
					holdState_d = HOLD_ARMED;
				end
			end
			// The writing instruction itself finishes first
			HOLD_ARMED: begin
				if (instrDone) begin
					holdState_d = HOLD_WAIT;
					holdCnt_d   = HOLD_INSTR;
				end
			end
			HOLD_WAIT: begin
				if (anyCfgWrite) begin
					holdState_d = HOLD_ARMED;
				end else if (instrDone) begin
					holdCnt_d = holdCnt_q - 2'h1;
					if (holdCnt_q == 2'h1) begin
						holdState_d = HOLD_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			holdState_q <= HOLD_IDLE;
			holdCnt_q   <= 2'h0;
		end else if (clkEn) begin
			holdState_q <= holdState_d;
			holdCnt_q   <= holdCnt_d;
		end
	end

	assign holdActive = (holdState_q != HOLD_IDLE) || anyCfgWrite;

	////////////////////////////////////////////////////////////////////////
	// Request to CPU

	wire logic  reqNext;
	wire logic  ackThisCycle;

	// Drop the request in the accept cycle so the next pick sees cleared flags
	assign ackThisCycle = cpuAck;
	assign reqNext      = anyQualified && !holdActive && !ackThisCycle;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intReq_q <= 1'b0;
			intIdx_q <= IDX_NONE;
		end else if (clkEn) begin
			intReq_q <= reqNext;
			intIdx_q <= reqNext ? pickIdx : IDX_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	wire logic [15:0] rdMux;
	wire logic [15:0] rdLaneMask;

	assign rdLaneMask = {{8{sfrByteEn[1]}}, {8{sfrByteEn[0]}}};
	assign rdMux = hitComm   ? reqFlagsCommMisc     :
	               hitAnalog ? reqFlagsAnalogTimers :
	                           16'h0000;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sfrRdata_q <= 16'h0000;
		end else if (clkEn && sfrRd) begin
			sfrRdata_q <= rdMux & rdLaneMask;
		end
	end

endmodule : irf_request_flags

// *** sim/irf_cpu_model.sv ***
// Behavioural CPU core: accepts requests, reports finished instructions.
// Assumes registered request outputs on mclk.
`timescale 1ns/100ps
module irf_cpu_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Bench controls
	input  wire logic       run,
	input  wire logic [3:0] ackLat,
	// Block side
	input  wire logic       intReq_q,
	input  wire logic [4:0] intIdx_q,
	output logic            instrDone,
	output logic            cpuAck,
	output logic [4:0]      cpuAckIdx
);
	logic [3:0] wait_q;
	logic [1:0] ins_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{wait_q, ins_q, instrDone, cpuAck, cpuAckIdx} <= '0;
		end else begin
			ins_q     <= run ? ins_q + 2'h1 : 2'h0;
			instrDone <= run && ins_q == 2'h2;
			cpuAck    <= 1'b0;
			// Index toggles while unused
			cpuAckIdx <= ~cpuAckIdx;
			wait_q    <= intReq_q && run && !cpuAck ? wait_q + 4'h1 : 4'h0;
			if (intReq_q && run && !cpuAck && wait_q >= ackLat) begin
				cpuAck    <= 1'b1;
				cpuAckIdx <= intIdx_q;
			end
		end
	end
endmodule : irf_cpu_model

// *** sim/irf_request_flags_sva.sv ***
// Checker on the request flag block ports.
// Assumes clkEn is held high and one clock domain.
`timescale 1ns/100ps
module irf_request_flags_sva
	import irf_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        clkEn,
	input wire logic [15:0] sfrAddr,
	input wire logic [1:0]  sfrByteEn,
	input wire logic        sfrWr,
	input wire logic [15:0] sfrWdata,
	input wire logic        uartTxReq,
	input wire logic        masterIntEnable,
	input wire logic        enableWrCommMisc,
	input wire logic        cpuAck,
	input wire logic [4:0]  cpuAckIdx,
	input wire logic        intReq_q,
	input wire logic [4:0]  intIdx_q,
	input wire logic [15:0] reqFlagsCommMisc,
	input wire logic [15:0] reqFlagsAnalogTimers
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence sAckTx; clkEn && cpuAck && cpuAckIdx == 5'h05; endsequence
	sequence sCfgWr; enableWrCommMisc && !intReq_q ##1 !intReq_q; endsequence
	////////////////////////////////////////////////////////////////
	a_reset_flags_zero: assert property ($rose(rst_n) |-> (reqFlagsCommMisc | reqFlagsAnalogTimers) == 16'h0000)
		else $error("flags not clear after reset");
	a_source_sets_flag: assert property (clkEn && uartTxReq |=> reqFlagsCommMisc[5])
		else $error("source event did not set flag");
	a_ack_clears_flag: assert property (sAckTx ##0 !uartTxReq && !sfrWr |=> !reqFlagsCommMisc[5])
		else $error("accepted flag not cleared");
	a_set_beats_clear: assert property (sAckTx ##0 uartTxReq |=> reqFlagsCommMisc[5])
		else $error("event lost against acceptance");
	a_req_needs_master: assert property (intReq_q |-> $past(masterIntEnable))
		else $error("request without master enable");
	a_storage_no_req: assert property (intReq_q |-> !(intIdx_q inside {[5'h07:5'h0C], 5'h12, 5'h13, 5'h16, 5'h17}))
		else $error("request from storage bit");
	a_ack_drops_req: assert property (clkEn && cpuAck |=> !intReq_q)
		else $error("request stays after acceptance");
	a_write_sets_flag: assert property (clkEn && sfrWr && sfrAddr == ADDR_REQ_ANALOG && sfrByteEn[1] && sfrWdata[15]
		|=> reqFlagsAnalogTimers[15])
		else $error("write of one did not set flag");
	a_cfg_write_hold: assert property (sCfgWr |=> !intReq_q [*2])
		else $error("request too soon after enable write");
endmodule : irf_request_flags_sva
bind irf_request_flags irf_request_flags_sva u_sva (.*);

// *** sim/irf_request_flags_tb.sv ***
// Self-checking bench for the request flag block.
// Assumes the checker binds itself and a CPU model answers.
`timescale 1ns/100ps
module irf_request_flags_tb
	import irf_pkg::*;
;
	logic        mclk = 1'b0, rst_n, sWr, sRd, master_int_enable, run, instrDone, cpuAck, intReq, ce;
	logic [15:0] sAddr, sWd, cSrc, aSrc, cEn, aEn, rdata, v;
	logic [1:0]  sBe, enWr;
	logic [3:0]  ackLat;
	logic [4:0]  ackIdx, intIdx, idx;
	int          n_mismatch = 0, compares = 0;
	always #12.5 mclk = ~mclk;
	irf_request_flags uut (.mclk, .rst_n, .clkEn(ce), .sfrAddr(sAddr), .sfrByteEn(sBe), .sfrWr(sWr),
		.sfrRd(sRd), .sfrWdata(sWd), .sfrRdata_q(rdata), .syncSerial0Req(cSrc[0]), .syncSerial0FifoReq(cSrc[1]),
		.twowire0Req(cSrc[2]), .twowire1Req(cSrc[3]), .uartRxReq(cSrc[4]), .uartTxReq(cSrc[5]),
		.uartFifoReq(cSrc[6]), .lowspeedOscSwitchReq(cSrc[13]), .voltageLevelSenseReq(cSrc[14]),
		.melody0Req(cSrc[15]), .sarAdcReq(aSrc[0]), .rcAdcReq(aSrc[1]), .comparator0Req(aSrc[4]),
		.comparator1Req(aSrc[5]), .timer8Req(aSrc[15:8]), .enableFlagsCommMisc(cEn),
		.enableFlagsAnalogTimers(aEn), .masterIntEnable(master_int_enable), .enableWrCommMisc(enWr[0]),
		.enableWrAnalogTimers(enWr[1]), .instrDone, .cpuAck, .cpuAckIdx(ackIdx), .intReq_q(intReq),
		.intIdx_q(intIdx), .reqFlagsCommMisc(), .reqFlagsAnalogTimers());
	irf_cpu_model u_cpu (.mclk, .rst_n, .run, .ackLat, .intReq_q(intReq), .intIdx_q(intIdx), .instrDone,
		.cpuAck, .cpuAckIdx(ackIdx));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [1:0] b, input logic [15:0] d);
		@(negedge mclk);
		{sAddr, sBe, sWd, sWr} = {a, b, d, 1'b1};
		@(negedge mclk);
		sWr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge mclk);
		{sAddr, sBe, sRd} = {a, 2'h3, 1'b1};
		@(negedge mclk);
		sRd = 1'b0;
		d = rdata;
	endtask : rd
	task automatic wait_ack(output logic [4:0] i);
		int n;
		n = 0;
		do begin @(negedge mclk); n++; end while (cpuAck !== 1'b1 && n < 60);
		i = ackIdx;
	endtask : wait_ack
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(ADDR_REQ_COMM, v); chk(v, 16'h0000);
		rd(ADDR_REQ_ANALOG, v); chk(v, 16'h0000);
	endtask : t_reset
	// Frozen clock enable must swallow a source event
	task automatic t_freeze;
		@(negedge mclk) {ce, cSrc[0]} = 2'h1;
		@(negedge mclk) cSrc = 16'h0000;
		@(negedge mclk) ce = 1'b1;
		rd(ADDR_REQ_COMM, v); chk(v, 16'h0000);
	endtask : t_freeze
	task automatic t_src_map;
		logic [15:0] m;
		for (int g = 0; g < 2; g++) begin
			m = g ? 16'hFF33 : 16'hE07F;
			for (int b = 0; b < 16; b++) if (m[b]) begin
				@(negedge mclk) {aSrc, cSrc} = 32'h1 << (g * 16 + b);
				@(negedge mclk) {aSrc, cSrc} = 32'h0;
				rd(g ? ADDR_REQ_ANALOG : ADDR_REQ_COMM, v); chk(v, 16'h1 << b);
				wr(g ? ADDR_REQ_ANALOG : ADDR_REQ_COMM, 2'h3, 16'h0000);
			end
		end
	endtask : t_src_map
	task automatic t_sw_write;
		wr(ADDR_REQ_COMM, 2'h1, 16'hFFFF); rd(ADDR_REQ_COMM, v); chk(v, 16'h00FF);
		wr(ADDR_REQ_COMM, 2'h2, 16'h1F00); rd(ADDR_REQ_COMM, v); chk(v, 16'h1FFF);
		wr(ADDR_REQ_ANALOG, 2'h3, 16'hFFFF); wr(16'hF01E, 2'h3, 16'h0000);
		rd(ADDR_REQ_ANALOG, v); chk(v, 16'hFFFF);
		rd(16'hF01E, v); chk(v, 16'h0000);
		wr(ADDR_REQ_COMM, 2'h3, 16'h0000); wr(ADDR_REQ_ANALOG, 2'h3, 16'h0000);
	endtask : t_sw_write
	task automatic t_accept;
		{cEn, aEn, ackLat} = {16'h0020, 16'h0800, 4'h3};
		@(negedge mclk) {cSrc[5], aSrc[11]} = 2'h3;
		@(negedge mclk) aSrc = 16'h0000;
		repeat (10) @(negedge mclk);
		chk({15'h0, intReq}, 16'h0000);
		{master_int_enable, run} = 2'h3;
		wait_ack(idx); chk({11'h0, idx}, 16'h0005);
		run = 1'b0;
		@(negedge mclk) cSrc = 16'h0000;
		rd(ADDR_REQ_COMM, v); chk(v, 16'h0020);
		rd(ADDR_REQ_ANALOG, v); chk(v, 16'h0800);
		wr(ADDR_REQ_COMM, 2'h3, 16'h0000);
		run = 1'b1;
		wait_ack(idx); chk({11'h0, idx}, 16'h001B);
		run = 1'b0;
		rd(ADDR_REQ_ANALOG, v); chk(v, 16'h0000);
	endtask : t_accept
	task automatic t_hold;
		ackLat = 4'h0;
		@(negedge mclk) enWr = 2'h3;
		@(negedge mclk) enWr = 2'h0;
		wr(ADDR_REQ_COMM, 2'h1, 16'h0020);
		repeat (8) @(negedge mclk);
		chk({15'h0, intReq}, 16'h0000);
		run = 1'b1;
		wait_ack(idx); chk({11'h0, idx}, 16'h0005);
		run = 1'b0;
	endtask : t_hold
	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		{sAddr, sBe, sWr, sRd, sWd, cSrc, aSrc, cEn, aEn, master_int_enable, enWr, run, ackLat} = '0;
		ce = 1'b1;
		rst_n = 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		t_reset;
		t_freeze;
		t_src_map;
		t_sw_write;
		t_accept;
		t_hold;
		tally_and_finish;
	end
	initial begin
		#125000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule : irf_request_flags_tb
